// File: core/status_regs.svh
// Purpose: constants for the output and input fault status bytes
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only, no logic
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

// command codes that select a status byte or an action
`define REG_VOUT_STATUS     8'h7A
`define REG_IOUT_STATUS     8'h7B
`define REG_INPUT_STATUS    8'h7C
`define CMD_CLEAR_FAULTS    8'h03

// reset value of every status byte
`define STATUS_RESET        8'h00

// output voltage status byte fields
`define VOUT_OV_BIT         7
`define VOUT_UV_BIT         4
`define VOUT_LIMIT_BIT      3
`define VOUT_USED_MASK      8'h98

// output current status byte fields
`define OCUR_FAULT_BIT      7
`define OCUR_WARN_BIT       5
`define OCUR_USED_MASK      8'hA0

// input status byte fields
`define IN_OV_BIT           7
`define IN_UV_BIT           4
`define IN_OC_BIT           2
`define IN_OCW_BIT          1
`define IN_USED_MASK        8'h96
`define IN_UV_MASK          8'h10

// serial engine constants
`define BYTE_LAST_BIT       3'h7
`define TARGET_ADDR_DEFAULT 7'h58

`endif

// File: core/status_pkg.sv
// Purpose: types shared by the status byte bank and its serial engine
// Assumes: nothing
// Notes:   state of each module is one packed struct
package status_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b000,
    ENG_RX    = 3'b001,
    ENG_ACK   = 3'b010,
    ENG_TX    = 3'b011,
    ENG_TXACK = 3'b100,
    ENG_TXRE  = 3'b101
  } eng_state_t;

  // whole state of the serial engine
  typedef struct packed {
    eng_state_t  st;
    logic [2:0]  bitcnt;
    logic [7:0]  sh;
    logic        first;
    logic        rd;
    logic        sda_oe;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic        stop_p;
    logic        addr_p;
    logic        rx_p;
    logic [7:0]  rx_data;
  } eng_t;

  // whole state of the status byte bank
  typedef struct packed {
    logic [7:0]  vout;
    logic [7:0]  iout;
    logic [7:0]  inp;
    logic [7:0]  cmd;
    logic        expect_cmd;
    logic [7:0]  rdata;
    logic        alert_oe;
    logic        pin_low;
    logic        vout_sum;
  } stat_t;

endpackage

// File: core/smbus_engine.sv
// Purpose: byte level serial target for the management bus
// Assumes: scl and sda arrive from outside the clock domain
// Notes:   acks its address and every written byte; sends tx_data_in on reads
`timescale 1ns/1ns
`default_nettype none
`include "status_regs.svh"

module smbus_engine
  import status_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
  input  wire logic       mclk_in,     // system clock
  input  wire logic       reset_n_in,  // synchronous reset, active low
  input  wire logic       scl_in,      // bus clock pin level
  input  wire logic       sda_in,      // bus data pin level
  input  wire logic [7:0] tx_data_in,  // byte to send on a read
  output logic            sda_oe_out,  // pull data line low
  output logic            stop_out,    // stop seen, one cycle
  output logic            addr_out,    // address matched, one cycle
  output logic            rd_out,      // direction bit of the last address byte, matched or not
  output logic            rx_out,      // data byte received, one cycle
  output logic [7:0]      rx_data_out  // received byte
);

  eng_t       q;
  eng_t       d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] byte_in;

  // edges and conditions on the synchronised pins
  assign scl_rise   = q.scl_s2 & ~q.scl_s3;
  assign scl_fall   = ~q.scl_s2 & q.scl_s3;
  assign start_seen = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_seen  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign byte_in    = {q.sh[6:0], q.sda_s2};

  // next state of the engine
  always_comb begin
    d        = q;
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    d.stop_p = 1'b0;
    d.addr_p = 1'b0;
    d.rx_p   = 1'b0;
    if (start_seen) begin
      d.st     = ENG_RX;
      d.bitcnt = 3'h0;
      d.first  = 1'b1;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      d.st     = ENG_IDLE;
      d.sda_oe = 1'b0;
      d.stop_p = 1'b1;
    end else begin
      case (q.st)
        ENG_RX: begin
          if (scl_rise) begin
            d.sh     = byte_in;
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == `BYTE_LAST_BIT) begin
              d.st = ENG_ACK;
              if (q.first) begin
                d.rd     = byte_in[0];
                d.addr_p = (byte_in[7:1] == TARGET_ADDR);
                if (byte_in[7:1] != TARGET_ADDR) begin
                  d.st = ENG_IDLE;  // not ours, stay quiet
                end
              end else begin
                d.rx_p    = 1'b1;
                d.rx_data = byte_in;
              end
            end
          end
        end
        ENG_ACK: begin
          if (scl_fall && !q.sda_oe) begin
            d.sda_oe = 1'b1;  // ack bit window opens
          end else if (scl_fall) begin
            d.first  = 1'b0;
            d.bitcnt = 3'h0;
            if (q.rd) begin
              d.st     = ENG_TX;
              d.sh     = tx_data_in;
              d.sda_oe = ~tx_data_in[7];
            end else begin
              d.st     = ENG_RX;
              d.sda_oe = 1'b0;
            end
          end
        end
        ENG_TX: begin
          if (scl_fall) begin
            d.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == `BYTE_LAST_BIT) begin
              d.st     = ENG_TXACK;
              d.sda_oe = 1'b0;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        ENG_TXACK: begin
          if (scl_rise) begin
            d.st = q.sda_s2 ? ENG_IDLE : ENG_TXRE;  // nack ends the read
          end
        end
        ENG_TXRE: begin
          if (scl_fall) begin
            d.st     = ENG_TX;
            d.bitcnt = 3'h0;
            d.sh     = tx_data_in;
            d.sda_oe = ~tx_data_in[7];
          end
        end
        default: d.st = ENG_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign sda_oe_out  = q.sda_oe;
  assign stop_out    = q.stop_p;
  assign addr_out    = q.addr_p;
  assign rd_out      = q.rd;
  assign rx_out      = q.rx_p;
  assign rx_data_out = q.rx_data;

endmodule
`default_nettype wire

// File: core/fault_status_bank.sv
// Purpose: output voltage, output current and input fault status bytes
// Assumes: fault inputs are levels from logic on mclk_in
// Notes:   bus pins pass three flip-flops inside smbus_engine
//
// Operation
// - read of 7Ah returns output voltage status byte, 00h after reset
// - read of 7Bh returns output current status byte, 00h after reset
// - read of 7Ch returns input status byte, 00h after reset
// - output voltage bit 7 latches an output over-voltage fault
// - output voltage bit 4 latches an output under-voltage fault
// - output voltage bits 6, 5, 2, 1, 0 always read zero
// - output current bit 7 latches an output over-current fault
// - output current bit 5 latches an output over-current warning
// - output current bits 6, 4, 3, 2, 1, 0 always read zero
// - status bytes are read-only and supported flags hold until a clear-faults command
// - input bits 7, 4, 2, 1 latch over-voltage, under-voltage, OC fault, OC warning
// - any output voltage flag sets the status word voltage summary
// - every flag except input under-voltage raises the host alert
`timescale 1ns/1ns
`default_nettype none
`include "status_regs.svh"

module fault_status_bank
  import status_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT
) (
  input  wire logic mclk_in,                 // system clock, 50 MHz
  input  wire logic reset_n_in,              // synchronous reset, active low
  input  wire logic scl_in,                  // bus clock pin
  input  wire logic sda_in,                  // bus data pin, received level
  input  wire logic out_ov_fault_in,         // output over-voltage detected
  input  wire logic out_uv_fault_in,         // output under-voltage detected
  input  wire logic vout_over_limit_in,      // voltage request above limit
  input  wire logic out_oc_fault_in,         // output over-current detected
  input  wire logic out_oc_warn_in,          // output over-current warning
  input  wire logic in_ov_fault_in,          // input over-voltage detected
  input  wire logic in_uv_fault_in,          // input under-voltage detected
  input  wire logic in_oc_fault_in,          // input over-current detected
  input  wire logic in_oc_warn_in,           // input over-current warning
  output logic      sda_out,                 // bus data drive level, low
  output logic      sda_oe_out,              // bus data driven low
  output logic      host_alert_output_out,   // alert drive level, low
  output logic      host_alert_oe_out,       // alert driven low
  output logic      vout_summary_out         // status word voltage summary
);

  stat_t      q;
  stat_t      d;
  logic       eng_stop;
  logic       eng_addr;
  logic       eng_rd;
  logic       eng_rx;
  logic [7:0] eng_rx_data;
  logic       clr;
  logic [7:0] vout_ev;
  logic [7:0] iout_ev;
  logic [7:0] inp_ev;
  logic [7:0] alert_new;

  ////////////////////////////////////////////////////////////////////////////
  // serial engine

  smbus_engine #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_engine (
    .mclk_in     (mclk_in),
    .reset_n_in  (reset_n_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .tx_data_in  (q.rdata),
    .sda_oe_out  (sda_oe_out),
    .stop_out    (eng_stop),
    .addr_out    (eng_addr),
    .rd_out      (eng_rd),
    .rx_out      (eng_rx),
    .rx_data_out (eng_rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  // byte returned for a selected command, zero for anything unmapped
  function automatic logic [7:0] read_mux(input logic [7:0] cmd,
                                          input logic [7:0] vout,
                                          input logic [7:0] iout,
                                          input logic [7:0] inp);
    if (cmd == `REG_VOUT_STATUS) begin
      return vout;
    end else if (cmd == `REG_IOUT_STATUS) begin
      return iout;
    end else if (cmd == `REG_INPUT_STATUS) begin
      return inp;
    end else begin
      return `STATUS_RESET;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event vectors

  // clear-faults arrives as the command byte of a write
  assign clr = eng_rx & q.expect_cmd & (eng_rx_data == `CMD_CLEAR_FAULTS);

  // events placed at their field positions
  assign vout_ev = (8'(out_ov_fault_in) << `VOUT_OV_BIT)
                 | (8'(out_uv_fault_in) << `VOUT_UV_BIT)
                 | (8'(vout_over_limit_in) << `VOUT_LIMIT_BIT);
  assign iout_ev = (8'(out_oc_fault_in) << `OCUR_FAULT_BIT)
                 | (8'(out_oc_warn_in) << `OCUR_WARN_BIT);
  assign inp_ev  = (8'(in_ov_fault_in) << `IN_OV_BIT)
                 | (8'(in_uv_fault_in) << `IN_UV_BIT)
                 | (8'(in_oc_fault_in) << `IN_OC_BIT)
                 | (8'(in_oc_warn_in) << `IN_OCW_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    // set wins over clear, so a live condition relatches at once
    d.vout = ((clr ? `STATUS_RESET : q.vout) | vout_ev)
           & `VOUT_USED_MASK;
    d.iout = ((clr ? `STATUS_RESET : q.iout) | iout_ev)
           & `OCUR_USED_MASK;
    d.inp  = ((clr ? `STATUS_RESET : q.inp) | inp_ev)
           & `IN_USED_MASK;
    d.vout_sum = |d.vout;
    // flags newly set against the cleared base, input under-voltage excluded
    alert_new  = (d.vout & ~(clr ? `STATUS_RESET : q.vout))
               | (d.iout & ~(clr ? `STATUS_RESET : q.iout))
               | (d.inp & ~(clr ? `STATUS_RESET : q.inp) & ~`IN_UV_MASK);
    d.alert_oe = (q.alert_oe & ~clr) | (|alert_new);
    d.pin_low  = 1'b0;
    // command tracking; data bytes written to any code are dropped
    if (eng_addr) begin
      d.expect_cmd = ~eng_rd;
    end else if (eng_rx && q.expect_cmd) begin
      d.cmd        = eng_rx_data;
      d.expect_cmd = 1'b0;
    end else if (eng_stop) begin
      d.expect_cmd = 1'b0;
    end
    d.rdata = read_mux(q.cmd, q.vout, q.iout, q.inp);
  end

  // state register, all bytes zero after reset
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign sda_out               = q.pin_low;
  assign host_alert_output_out = q.pin_low;
  assign host_alert_oe_out     = q.alert_oe;
  assign vout_summary_out      = q.vout_sum;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a clear-faults command taken by the bank
  sequence s_clear;
    clr;
  endsequence

  // the flag it cleared comes back one cycle later
  sequence s_relatch;
    ##1 q.vout[`VOUT_OV_BIT];
  endsequence

  a_reset_zero: assert property (
    @(posedge mclk_in) $rose(reset_n_in) |->
      (q.vout == `STATUS_RESET && q.iout == `STATUS_RESET && q.inp == `STATUS_RESET))
    else $error("status bytes not zero after reset");

  a_read_select: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (q.cmd == `REG_IOUT_STATUS) ##1 (q.cmd == `REG_IOUT_STATUS)
        |-> q.rdata == $past(q.iout))
    else $error("read byte does not follow selected status byte");

  a_ov_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      out_ov_fault_in |=> q.vout[`VOUT_OV_BIT])
    else $error("output over-voltage flag not latched");

  a_uv_limit: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (out_uv_fault_in && vout_over_limit_in)
        |=> (q.vout[`VOUT_UV_BIT] && q.vout[`VOUT_LIMIT_BIT]))
    else $error("under-voltage or limit flag not latched");

  a_unused_zero: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      ((q.vout & ~`VOUT_USED_MASK) == 8'h00) && ((q.iout & ~`OCUR_USED_MASK) == 8'h00))
    else $error("unsupported status bit reads one");

  a_current_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (out_oc_fault_in && out_oc_warn_in)
        |=> (q.iout[`OCUR_FAULT_BIT] && q.iout[`OCUR_WARN_BIT]))
    else $error("output current flags not latched");

  a_flag_hold: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (q.iout[`OCUR_FAULT_BIT] && !clr) |=> q.iout[`OCUR_FAULT_BIT])
    else $error("output current flag dropped without clear");

  a_input_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_oc_warn_in |=> q.inp[`IN_OCW_BIT] [*1] ##0 (q.inp[`IN_UV_BIT] == $past(q.inp[`IN_UV_BIT]
        | in_uv_fault_in) || $past(clr)))
    else $error("input status flag wrong");

  a_summary_follow: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      out_uv_fault_in |=> (q.vout != 8'h00) ##0 vout_summary_out)
    else $error("voltage summary not set");

  a_alert_rise: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      ($rose(q.inp[`IN_OC_BIT]) || $rose(q.vout[`VOUT_OV_BIT])) |-> host_alert_oe_out)
    else $error("alert not raised by new flag");

  a_uv_quiet: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (!host_alert_oe_out && q.vout == 8'h00 && q.iout == 8'h00
        && (q.inp & ~`IN_UV_MASK) == 8'h00 && !(|vout_ev) && !(|iout_ev)
        && !in_ov_fault_in && !in_oc_fault_in && !in_oc_warn_in) |=> !host_alert_oe_out)
    else $error("alert raised by input under-voltage alone");

  a_clear_flags: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (clr && !(|vout_ev) && !(|iout_ev) && !(|inp_ev)) |=>
        (q.vout == 8'h00 && q.iout == 8'h00 && q.inp == 8'h00 && !host_alert_oe_out))
    else $error("clear-faults did not clear");

  a_write_ignored: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (eng_rx && !q.expect_cmd && !(|vout_ev)) |=> $stable(q.vout))
    else $error("data byte altered status");

  a_relatch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (s_clear ##0 out_ov_fault_in) |-> s_relatch)
    else $error("present fault lost at clear");

  // a clear taken while a fault condition is still present
  sequence s_clear_live;
    clr ##0 (out_ov_fault_in || out_oc_fault_in || in_ov_fault_in);
  endsequence

  a_alert_relatch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_clear_live |=> host_alert_oe_out)
    else $error("alert not raised again by a live fault at clear");

  a_read_vout: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (q.cmd == `REG_VOUT_STATUS) ##1 (q.cmd == `REG_VOUT_STATUS)
        |-> q.rdata == $past(q.vout))
    else $error("read byte does not follow output voltage status");

  a_read_input: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (q.cmd == `REG_INPUT_STATUS) ##1 (q.cmd == `REG_INPUT_STATUS)
        |-> q.rdata == $past(q.inp))
    else $error("read byte does not follow input status");

  // a command that selects none of the three bytes, held two cycles
  sequence s_unmapped_held;
    (read_mux(q.cmd, 8'hFF, 8'hFF, 8'hFF) == `STATUS_RESET) [*2];
  endsequence

  a_read_unmapped: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      s_unmapped_held |-> q.rdata == `STATUS_RESET)
    else $error("unmapped command returned a nonzero byte");

  a_input_unused: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      (q.inp & ~`IN_USED_MASK) == 8'h00)
    else $error("unsupported input status bit reads one");

  a_input_ov_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_ov_fault_in |=> q.inp[`IN_OV_BIT])
    else $error("input over-voltage flag not latched");

  a_input_oc_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_oc_fault_in |=> q.inp[`IN_OC_BIT])
    else $error("input over-current flag not latched");

  a_input_uv_latch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      in_uv_fault_in |=> q.inp[`IN_UV_BIT])
    else $error("input under-voltage flag not latched");

  a_summary_match: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
      vout_summary_out == (q.vout != 8'h00))
    else $error("voltage summary differs from the status byte");

endmodule
`default_nettype wire

// File: testbench/pmbus_host_model.sv
// Purpose: host on the management bus that reads and clears the status bytes
// Assumes: bus clock half period of four system clocks (160 ns period)
// Notes:   data line open drain, clock driven to both levels; clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
`include "status_regs.svh"

module pmbus_host_model (
  input  wire logic mclk_in,    // system clock, paces the bus
  input  wire logic sda_in,     // resolved data line level
  output logic      scl_out,    // bus clock, idles high
  output logic      sda_oe_out  // high pulls data line low
);
  // idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // one half period of the bus clock
  task automatic half();
    repeat (4) @(negedge mclk_in);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_oe_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_oe_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask

  // stop ends the frame; clock then stands high
  task automatic stop();
    @(negedge mclk_in);
    sda_oe_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_oe_out = 1'b0;
    half();
  endtask

  // one bit slot: data changes only while the clock is low
  task automatic bit_slot(input logic b, output logic r);
    sda_oe_out = ~b;
    half();
    scl_out = 1'b1;
    half();
    r = sda_in;
    scl_out = 1'b0;
  endtask

  // byte out, msb first, then the target's ack
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, r);
    ack = ~r;
  endtask

  // byte in, msb first; nack ends the read
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack, r);
  endtask

  // clear-faults command: address, code, stop
  task automatic clear(input logic [6:0] addr, output logic ack);
    logic a;
    start();
    write_byte({addr, 1'b0}, a);
    write_byte(`CMD_CLEAR_FAULTS, ack);
    stop();
  endtask
endmodule

`default_nettype wire

// File: testbench/output_and_input_fault_status_bytes_bench.sv
// Purpose: self-checking bench for the fault status byte bank
// Assumes: host partner model drives the bus; faults driven at falling edge
// Notes:   status bytes compared with an integer model after each event
`timescale 1ns/1ns
`default_nettype none
`include "status_regs.svh"

module output_and_input_fault_status_bytes_bench;
  import status_pkg::*;
  localparam logic [6:0] ADDR = `TARGET_ADDR_DEFAULT;
  logic       mclk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [8:0] flt = 9'h000;
  logic       scl, host_oe, dut_oe, sda_drv, alert_drv, alert_oe, vsum;
  wire        sda_w = ~(host_oe | dut_oe);
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         mv, mi, mn;
  logic [7:0] d;
  logic       a;

  // 50 MHz system clock
  always #10 mclk_in = ~mclk_in;

  fault_status_bank #(.TARGET_ADDR(ADDR)) fault_status_bank_inst (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w),
    .out_ov_fault_in(flt[8]), .out_uv_fault_in(flt[7]), .vout_over_limit_in(flt[6]),
    .out_oc_fault_in(flt[5]), .out_oc_warn_in(flt[4]), .in_ov_fault_in(flt[3]),
    .in_uv_fault_in(flt[2]), .in_oc_fault_in(flt[1]), .in_oc_warn_in(flt[0]),
    .sda_out(sda_drv), .sda_oe_out(dut_oe), .host_alert_output_out(alert_drv),
    .host_alert_oe_out(alert_oe), .vout_summary_out(vsum));

  pmbus_host_model pmbus_host_model_inst (
    .mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_oe_out(host_oe));

  // verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // model: latch the supported bits of one set of fault events
  task automatic latch(input logic [8:0] f);
    mv = mv | {f[8], 2'b00, f[7], f[6], 3'b000};
    mi = mi | {f[5], 1'b0, f[4], 5'b00000};
    mn = mn | {f[3], 2'b00, f[2], 1'b0, f[1], f[0], 1'b0};
  endtask

  // one cycle pulse on the fault inputs
  task automatic pulse(input logic [8:0] f);
    @(negedge mclk_in);
    flt = f;
    @(negedge mclk_in);
    flt = 9'h000;
    latch(f);
  endtask

  // single byte read: write command, repeated start, read, nack, stop
  task automatic rd(input logic [7:0] cmd, output logic [7:0] q);
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.write_byte({ADDR, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    pmbus_host_model_inst.write_byte(cmd, a);
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.write_byte({ADDR, 1'b1}, a);
    pmbus_host_model_inst.read_byte(1'b1, q);
    pmbus_host_model_inst.stop();
  endtask

  // all three bytes, an unmapped code, summary and alert against the model
  task automatic check_all();
    rd(`REG_VOUT_STATUS, d);
    check(d, mv[7:0]);
    rd(`REG_IOUT_STATUS, d);
    check(d, mi[7:0]);
    rd(`REG_INPUT_STATUS, d);
    check(d, mn[7:0]);
    rd(8'h7D, d);
    check(d, 8'h00);
    check({6'h00, sda_drv, alert_drv}, 8'h00);
    check({7'h00, vsum}, {7'h00, mv != 0});
    check({7'h00, alert_oe}, {7'h00, (mv | mi | (mn & 8'hEF)) != 0});
  endtask

  // bound on the whole run
  initial begin
    repeat (100000) @(posedge mclk_in);
    n_mismatch++;
    end_sim();
  end

  // main sequence
  initial begin
    void'($urandom(32'h817EE336));
    mv = 0;
    mi = 0;
    mn = 0;
    repeat (2) @(negedge mclk_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    check_all();
    // each flag alone, so every bit is set at least once
    for (int i = 0; i < 9; i++) begin
      pulse(9'h001 << i);
      check_all();
      pmbus_host_model_inst.clear(ADDR, a);
      mv = 0;
      mi = 0;
      mn = 0;
      check_all();
    end
    // random event mixes accumulate without clearing
    for (int r = 0; r < 5; r++) begin
      pulse(9'($urandom()));
      check_all();
    end
    // a write to the output voltage status byte is acked but changes nothing
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.write_byte({ADDR, 1'b0}, a);
    pmbus_host_model_inst.write_byte(`REG_VOUT_STATUS, a);
    pmbus_host_model_inst.write_byte(8'h00, a);
    pmbus_host_model_inst.stop();
    check_all();
    // wrong address is not acked and leaves the flags alone
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.write_byte({ADDR ^ 7'h01, 1'b0}, a);
    pmbus_host_model_inst.stop();
    check({7'h00, a}, 8'h00);
    // clear while output and input over-voltage are present: both set again
    @(negedge mclk_in);
    flt = 9'h108;
    pmbus_host_model_inst.clear(ADDR, a);
    @(negedge mclk_in);
    flt = 9'h000;
    mv = 8'h80;
    mi = 0;
    mn = 8'h80;
    check_all();
    // mid-run reset empties every byte
    pulse(9'h1FF);
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    reset_n_in = 1'b1;
    mv = 0;
    mi = 0;
    mn = 0;
    repeat (6) @(negedge mclk_in);
    check_all();
    end_sim();
  end
endmodule

`default_nettype wire
